// *** rtl/sfp_serial_port.sv ***
// framed full-duplex serial port: holding registers, mode bits, tx and rx shifters
//
// How it works
// - mode bit picks 16 or low 8 bits
// - word length cleared by reset, loadable
// - internal sync: pulse per holding write
// - external sync: wait for partner's pulse
// - sync source loadable, settable and clearable
// - reset clears source, floats data, aborts
// - sync-required bit set and cleared by ops
// - sync pulse loads shifter, restarts mid-word when sync required
// - start on sync fall, MSB first
// - receive samples on falling clock, MSB first
// - tx done raised on rising clock
// - data line floats when not transmitting
// - rx word to holding, done on rise
// - holding copied to shifter at start, or with own sync pulse
// - latest holding write is sent next
// - rx holding keeps old word until new
// - hold finishes word then floats line
// - holding registers at addresses 0 and 1
// - shifters have no software path
// - byte mode shifts low byte upward
// - no sync needed: repeat last word
`timescale 1ns/1ps
module sfp_serial_port (
	input  logic        clk,
	input  logic        sys_rst,
	input  logic [15:0] memAddr,
	input  logic        memWrEn,
	input  logic [15:0] memWrData,
	input  logic        memRdEn,
	input  logic        blockMove,
	output logic [15:0] memRdData,
	output logic        memRdHit,
	input  logic        opWordLenLoad,
	input  logic        opWordLenValue,
	input  logic        opStatusLoad,
	input  logic [2:0]  opStatusValue,
	input  logic        opSetSyncSource,
	input  logic        opClrSyncSource,
	input  logic        opSetSyncReq,
	input  logic        opClrSyncReq,
	input  logic        holdN,
	output logic        wordLengthSelect,
	output logic        txSyncSource,
	output logic        frameSyncRequired,
	output logic        txDoneIrq,
	output logic        rxDoneIrq,
	input  logic        txBitClk,
	output logic        txSerialOut,
	output logic        txSerialOe,
	input  logic        txFrameSyncIn,
	output logic        txFrameSyncOut,
	output logic        txFrameSyncOe,
	input  logic        rxBitClk,
	input  logic        rxSerialIn,
	input  logic        rxFrameSyncIn
);
	sfp_pkg::sfp_core_t core_ff;
	sfp_pkg::sfp_core_t nxt_core;
	sfp_pkg::sfp_tx_t   tx_ff;
	sfp_pkg::sfp_tx_t   nxt_tx;
	sfp_pkg::sfp_rx_t   rx_ff;
	sfp_pkg::sfp_rx_t   nxt_rx;
	logic               rxDone_ff;

	logic [5:0]  txSyncQ;
	logic [2:0]  rxSyncQ;
	logic        txRstS;
	logic        txHoldS;
	logic        txFoS;
	logic        txTxmS;
	logic        txFsmS;
	logic        txWrTglS;
	logic        rxRstS;
	logic        rxFoS;
	logic        rxFsmS;
	logic        txEvt;
	logic        rxEvt;
	logic [3:0]  txMsb;
	logic        txDone;
	logic        txStartInt;
	logic        txStartExt;
	logic        txStartCont;
	logic [15:0] txWord;
	logic [3:0]  rxMsb;
	logic        rxFsAct;

	// core-domain levels into the tx clock domain
	sfp_sync #(
		.WIDTH(6)
	) u_tx_sync (
		.clk(txBitClk),
		.d  ({sys_rst, holdN, core_ff.fo, core_ff.tx_sync_source, core_ff.fsm, core_ff.wrTgl}),
		.q  (txSyncQ)
	);

	sfp_sync #(
		.WIDTH(3)
	) u_rx_sync (
		.clk(rxBitClk),
		.d  ({sys_rst, core_ff.fo, core_ff.fsm}),
		.q  (rxSyncQ)
	);

	assign txRstS   = txSyncQ[5];
	assign txHoldS  = !txSyncQ[4];
	assign txFoS    = txSyncQ[3];
	assign txTxmS   = txSyncQ[2];
	assign txFsmS   = txSyncQ[1];
	assign txWrTglS = txSyncQ[0];
	assign rxRstS   = rxSyncQ[2];
	assign rxFoS    = rxSyncQ[1];
	assign rxFsmS   = rxSyncQ[0];

	// completion toggles back into the core clock
	sfp_evt_sync u_tx_evt (
		.clk    (clk),
		.sys_rst(sys_rst),
		.tgl    (tx_ff.doneTgl),
		.pulse  (txEvt)
	);

	sfp_evt_sync u_rx_evt (
		.clk    (clk),
		.sys_rst(sys_rst),
		.tgl    (rxDone_ff),
		.pulse  (rxEvt)
	);

	// core domain: holding registers, mode bits, reads
	always_comb begin
		nxt_core        = core_ff;
		nxt_core.txIrq  = txEvt;
		nxt_core.rxIrq  = rxEvt;
		nxt_core.rdData = '0;
		nxt_core.rdHit  = 1'b0;
		if (memWrEn) begin
			if (memAddr == `SFP_ADDR_TX_HOLD) begin
				nxt_core.txHold = memWrData;
				nxt_core.wrTgl  = !core_ff.wrTgl;
			end else if (memAddr == `SFP_ADDR_RX_HOLD) begin
				nxt_core.rxHold = memWrData;
			end
		end
		// a completed word wins over a software write in the same cycle
		if (rxEvt) begin
			if (core_ff.fo) begin
				nxt_core.rxHold = {core_ff.rxHold[7:0], rx_ff.word[7:0]};
			end else begin
				nxt_core.rxHold = rx_ff.word;
			end
		end
		// only the holding registers decode; shifters stay hidden
		if (memRdEn && !blockMove) begin
			if (memAddr == `SFP_ADDR_TX_HOLD) begin
				nxt_core.rdData = core_ff.txHold;
				nxt_core.rdHit  = 1'b1;
			end else if (memAddr == `SFP_ADDR_RX_HOLD) begin
				nxt_core.rdData = core_ff.rxHold;
				nxt_core.rdHit  = 1'b1;
			end
		end
		if (opStatusLoad) begin
			nxt_core.fo  = opStatusValue[`SFP_ST1_FO];
			nxt_core.tx_sync_source = opStatusValue[`SFP_ST1_TXM];
			nxt_core.fsm = opStatusValue[`SFP_ST1_FSM];
		end
		if (opWordLenLoad) begin
			nxt_core.fo = opWordLenValue;
		end
		if (opSetSyncSource) begin
			nxt_core.tx_sync_source = 1'b1;
		end
		if (opClrSyncSource) begin
			nxt_core.tx_sync_source = 1'b0;
		end
		if (opSetSyncReq) begin
			nxt_core.fsm = 1'b1;
		end
		if (opClrSyncReq) begin
			nxt_core.fsm = 1'b0;
		end
		if (sys_rst) begin
			nxt_core     = '0;
			nxt_core.fo  = `SFP_RST_FO;
			nxt_core.tx_sync_source = `SFP_RST_TXM;
			nxt_core.fsm = `SFP_RST_FSM;
		end
	end

	always_ff @(posedge clk) begin
		core_ff <= nxt_core;
	end

	// tx domain: every step on a rising bit clock
	always_comb begin
		nxt_tx      = tx_ff;
		txMsb       = txFoS ? `SFP_MSB_BYTE : `SFP_MSB_WORD;
		txDone      = (tx_ff.mode == sfp_pkg::TX_SHIFT) && (tx_ff.bitIdx == `SFP_BIT_DONE);
		txStartInt  = txTxmS && tx_ff.fsOut;
		txStartExt  = !txTxmS && tx_ff.fsPrev && !txFrameSyncIn && !txHoldS
			&& (txFsmS || (tx_ff.mode == sfp_pkg::TX_IDLE));
		txStartCont = !txFsmS && txDone && !txHoldS;
		nxt_tx.fsPrev = txFrameSyncIn;
		nxt_tx.fsOe   = txTxmS;
		nxt_tx.fsOut  = 1'b0;
		if (txWrTglS != tx_ff.wrSeen) begin
			nxt_tx.wrSeen   = txWrTglS;
			nxt_tx.pend     = 1'b1;
			nxt_tx.pendData = core_ff.txHold;
		end
		txWord = txStartInt ? tx_ff.shifter : nxt_tx.pendData;
		if (txDone) begin
			nxt_tx.doneTgl = !tx_ff.doneTgl;
			nxt_tx.mode    = sfp_pkg::TX_IDLE;
			nxt_tx.dOe     = 1'b0;
		end else if (tx_ff.mode == sfp_pkg::TX_SHIFT) begin
			nxt_tx.dOut   = tx_ff.shifter[tx_ff.bitIdx - `SFP_BIT_LAST];
			nxt_tx.bitIdx = tx_ff.bitIdx - `SFP_BIT_LAST;
		end
		// when pulses are needed, an external pulse mid-word aborts and reloads
		if (txStartInt || txStartExt || txStartCont) begin
			nxt_tx.mode    = sfp_pkg::TX_SHIFT;
			nxt_tx.shifter = txWord;
			nxt_tx.dOut    = txWord[txMsb];
			nxt_tx.dOe     = 1'b1;
			nxt_tx.bitIdx  = txMsb;
			if (!txStartInt) begin
				nxt_tx.pend = 1'b0;
			end
		end
		// own sync pulse: when idle, or over the final bit when pulses are needed
		if (txTxmS && !txHoldS && nxt_tx.pend && !tx_ff.fsOut
			&& ((nxt_tx.mode == sfp_pkg::TX_IDLE) || (txFsmS
			&& (tx_ff.mode == sfp_pkg::TX_SHIFT) && (tx_ff.bitIdx == `SFP_BIT_LAST)))) begin
			nxt_tx.fsOut   = 1'b1;
			nxt_tx.shifter = nxt_tx.pendData;
			nxt_tx.pend    = 1'b0;
		end
		if (txRstS) begin
			nxt_tx        = '0;
			nxt_tx.mode   = sfp_pkg::TX_IDLE;
			nxt_tx.wrSeen = txWrTglS;
		end
	end

	always_ff @(posedge txBitClk) begin
		tx_ff <= nxt_tx;
	end

	// rx domain: sampling on the falling bit clock
	always_comb begin
		nxt_rx  = rx_ff;
		rxMsb   = rxFoS ? `SFP_MSB_BYTE : `SFP_MSB_WORD;
		// sync ignored once running without required pulses
		rxFsAct = rxFrameSyncIn && (rxFsmS || (rx_ff.mode == sfp_pkg::RX_IDLE));
		if ((rx_ff.mode == sfp_pkg::RX_SHIFT)
			|| ((rx_ff.mode == sfp_pkg::RX_ARMED) && !rxFsAct)) begin
			nxt_rx.shifter = {rx_ff.shifter[14:0], rxSerialIn};
			if (rx_ff.mode == sfp_pkg::RX_ARMED) begin
				nxt_rx.mode = sfp_pkg::RX_SHIFT;
				nxt_rx.left = rxMsb;
			end else if (rx_ff.left == `SFP_BIT_LAST) begin
				nxt_rx.word    = {rx_ff.shifter[14:0], rxSerialIn};
				nxt_rx.doneTgl = !rx_ff.doneTgl;
				nxt_rx.mode    = rxFsmS ? sfp_pkg::RX_IDLE : sfp_pkg::RX_ARMED;
			end else begin
				nxt_rx.left = rx_ff.left - `SFP_BIT_LAST;
			end
		end
		// clock may stop between words; idle waits for a pulse
		if (rxFsAct) begin
			nxt_rx.mode = sfp_pkg::RX_ARMED;
		end
		if (rxRstS) begin
			nxt_rx      = '0;
			nxt_rx.mode = sfp_pkg::RX_IDLE;
		end
	end

	always_ff @(negedge rxBitClk) begin
		rx_ff <= nxt_rx;
	end

	// completion shown on the following rising edge
	always_ff @(posedge rxBitClk) begin
		if (rxRstS) begin
			rxDone_ff <= 1'b0;
		end else begin
			rxDone_ff <= rx_ff.doneTgl;
		end
	end

	assign memRdData         = core_ff.rdData;
	assign memRdHit          = core_ff.rdHit;
	assign wordLengthSelect  = core_ff.fo;
	assign txSyncSource      = core_ff.tx_sync_source;
	assign frameSyncRequired = core_ff.fsm;
	assign txDoneIrq         = core_ff.txIrq;
	assign rxDoneIrq         = core_ff.rxIrq;
	assign txSerialOut       = tx_ff.dOut;
	assign txSerialOe        = tx_ff.dOe;
	assign txFrameSyncOut    = tx_ff.fsOut;
	assign txFrameSyncOe     = tx_ff.fsOe;

	a_wl_reset: assert property (@(posedge clk) sys_rst |=> !wordLengthSelect)
		else $error("word length bit not cleared by reset");

	a_src_reset: assert property (@(posedge clk) sys_rst |=> !txSyncSource)
		else $error("sync source not cleared by reset");

	a_src_set: assert property (@(posedge clk) disable iff (sys_rst)
		opSetSyncSource && !opClrSyncSource |=> txSyncSource)
		else $error("sync source not set");

	a_req_clear: assert property (@(posedge clk) disable iff (sys_rst)
		opClrSyncReq |=> !frameSyncRequired)
		else $error("sync required not cleared");

	a_rx_word: assert property (@(posedge clk) disable iff (sys_rst)
		rxEvt && !core_ff.fo |=> (core_ff.rxHold == $past(rx_ff.word)) && rxDoneIrq)
		else $error("received word not moved to holding register");

	a_byte_pack: assert property (@(posedge clk) disable iff (sys_rst)
		rxEvt && core_ff.fo |=> core_ff.rxHold[15:8] == $past(core_ff.rxHold[7:0]))
		else $error("byte mode did not move low byte up");

	a_rx_keep: assert property (@(posedge clk) disable iff (sys_rst)
		!rxEvt && !(memWrEn && (memAddr == `SFP_ADDR_RX_HOLD)) |=> $stable(core_ff.rxHold))
		else $error("rx holding register changed without a new word");

	a_blk_read: assert property (@(posedge clk) disable iff (sys_rst)
		memRdEn && blockMove |=> !memRdHit && (memRdData == '0))
		else $error("block move read the holding registers");

	a_fs_pulse: assert property (@(posedge txBitClk) disable iff (txRstS)
		txFrameSyncOut |=> !txFrameSyncOut && txSerialOe)
		else $error("own sync pulse not followed by transmission");

	a_tx_hiz: assert property (@(posedge txBitClk) disable iff (txRstS)
		tx_ff.mode == sfp_pkg::TX_IDLE |-> !txSerialOe)
		else $error("data line driven while idle");

	a_tx_done: assert property (@(posedge txBitClk) disable iff (txRstS)
		txDone |=> tx_ff.doneTgl != $past(tx_ff.doneTgl))
		else $error("no completion after the last bit");

	a_fsx_in: assert property (@(posedge txBitClk) disable iff (txRstS)
		!txTxmS |=> !txFrameSyncOe && !txFrameSyncOut)
		else $error("sync pin driven while it is an input");
endmodule : sfp_serial_port

// *** common/sfp_cfg.svh ***
// register map, reset values, field positions and counts of the serial port
`ifndef SFP_CFG_SVH
`define SFP_CFG_SVH
`define SFP_ADDR_TX_HOLD 16'h0000
`define SFP_ADDR_RX_HOLD 16'h0001
`define SFP_RST_FO       1'b0
`define SFP_RST_TXM      1'b0
`define SFP_RST_FSM      1'b1
`define SFP_ST1_FO       0
`define SFP_ST1_TXM      1
`define SFP_ST1_FSM      2
`define SFP_MSB_WORD     4'hf
`define SFP_MSB_BYTE     4'h7
`define SFP_BIT_LAST     4'h1
`define SFP_BIT_DONE     4'h0
`endif

// *** common/sfp_pkg.sv ***
// state types of the serial port
`include "sfp_cfg.svh"
package sfp_pkg;
	typedef enum logic {TX_IDLE, TX_SHIFT} sfp_tx_mode_t;
	typedef enum logic [1:0] {RX_IDLE, RX_ARMED, RX_SHIFT} sfp_rx_mode_t;

	typedef struct packed {
		logic [15:0] txHold;
		logic [15:0] rxHold;
		logic        fo;
		logic        tx_sync_source;
		logic        fsm;
		logic        wrTgl;
		logic [15:0] rdData;
		logic        rdHit;
		logic        txIrq;
		logic        rxIrq;
	} sfp_core_t;

	typedef struct packed {
		sfp_tx_mode_t mode;
		logic [15:0]  shifter;
		logic [15:0]  pendData;
		logic [3:0]   bitIdx;
		logic         pend;
		logic         wrSeen;
		logic         fsPrev;
		logic         fsOut;
		logic         fsOe;
		logic         dOut;
		logic         dOe;
		logic         doneTgl;
	} sfp_tx_t;

	typedef struct packed {
		sfp_rx_mode_t mode;
		logic [15:0]  shifter;
		logic [15:0]  word;
		logic [3:0]   left;
		logic         doneTgl;
	} sfp_rx_t;
endpackage : sfp_pkg

// *** rtl/sfp_sync.sv ***
// two-flop level synchroniser for a small bundle of bits
`timescale 1ns/1ps
module sfp_sync #(
	parameter int WIDTH = 1
) (
	input  logic             clk,
	input  logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} sfp_sync_t;

	sfp_sync_t sync_ff;
	sfp_sync_t nxt_sync;

	always_comb begin
		nxt_sync        = sync_ff;
		nxt_sync.meta   = d;
		nxt_sync.stable = sync_ff.meta;
	end

	always_ff @(posedge clk) begin
		sync_ff <= nxt_sync;
	end

	assign q = sync_ff.stable;
endmodule : sfp_sync

// *** rtl/sfp_evt_sync.sv ***
// toggle crossing: one-cycle pulse per change of a far-domain toggle
`timescale 1ns/1ps
module sfp_evt_sync (
	input  logic clk,
	input  logic sys_rst,
	input  logic tgl,
	output logic pulse
);
	typedef struct packed {
		logic meta;
		logic stable;
		logic last;
		logic pulse;
	} sfp_evt_t;

	sfp_evt_t evt_ff;
	sfp_evt_t nxt_evt;

	always_comb begin
		nxt_evt        = evt_ff;
		nxt_evt.meta   = tgl;
		nxt_evt.stable = evt_ff.meta;
		nxt_evt.last   = evt_ff.stable;
		nxt_evt.pulse  = evt_ff.stable ^ evt_ff.last;
		if (sys_rst) begin
			nxt_evt = '0;
		end
	end

	always_ff @(posedge clk) begin
		evt_ff <= nxt_evt;
	end

	assign pulse = evt_ff.pulse;
endmodule : sfp_evt_sync

// *** sim/sfp_codec_model.sv ***
// far-side codec model: link clocks, rx frames, tx bit capture
`timescale 1ns/1ps
module sfp_codec_model (
	output logic txBitClk,
	output logic txFrameSyncIn,
	output logic rxBitClk,
	output logic rxSerialIn,
	output logic rxFrameSyncIn,
	input  logic txSerialOut,
	input  logic txSerialOe,
	input  logic txFrameSyncOut,
	input  logic txFrameSyncOe
);
	logic txBits[$];
	int   fsSeen = 0;

	initial {txBitClk, txFrameSyncIn, rxBitClk, rxSerialIn, rxFrameSyncIn} = 5'h00;

	// tx line read mid-period
	always @(negedge txBitClk) begin
		if (txSerialOe === 1'b1) txBits.push_back(txSerialOut);
		if (txFrameSyncOe === 1'b1 && txFrameSyncOut === 1'b1) fsSeen++;
	end

	// clocks run only in frames and stop low
	task automatic tx_run(input int n, input logic pulse);
		#3.3;
		for (int i = 0; i < n; i++) begin
			txBitClk = 1'b1;
			#15 txBitClk = 1'b0;
			txFrameSyncIn = pulse && i == 3;
			#15;
		end
	endtask : tx_run

	task automatic rx_send(input logic [15:0] w, input int n, input logic fs);
		#4.1;
		for (int i = -1; i < n + 3; i++) begin
			rxBitClk = 1'b1;
			rxFrameSyncIn = fs && i == -1;
			// released line keeps changing
			rxSerialIn = (i >= 0 && i < n) ? w[n-1-i] : ~rxSerialIn;
			#15 rxBitClk = 1'b0;
			#15;
		end
	endtask : rx_send
endmodule : sfp_codec_model

// *** sim/framed_serial_port_tb.sv ***
// self-checking bench of the framed serial port
`timescale 1ns/1ps
module framed_serial_port_tb;
	logic        clk, sys_rst, memWrEn, memRdEn, blockMove, memRdHit, holdN;
	logic [15:0] memAddr, memWrData, memRdData, seed, rxHold;
	logic [2:0]  opStatusValue, mode;
	logic        opWordLenLoad, opWordLenValue, opStatusLoad, opSetSyncSource;
	logic        opClrSyncSource, opSetSyncReq, opClrSyncReq;
	logic        wordLengthSelect, txSyncSource, frameSyncRequired, txDoneIrq, rxDoneIrq;
	logic        txBitClk, txSerialOut, txSerialOe, txFrameSyncIn, txFrameSyncOut;
	logic        txFrameSyncOe, rxBitClk, rxSerialIn, rxFrameSyncIn;
	int          errors, cmpCount, txIrqs, rxIrqs;

	sfp_serial_port u_sfp_serial_port (.clk, .sys_rst, .memAddr, .memWrEn, .memWrData,
		.memRdEn, .blockMove, .memRdData, .memRdHit, .opWordLenLoad, .opWordLenValue,
		.opStatusLoad, .opStatusValue, .opSetSyncSource, .opClrSyncSource, .opSetSyncReq,
		.opClrSyncReq, .holdN, .wordLengthSelect, .txSyncSource, .frameSyncRequired,
		.txDoneIrq, .rxDoneIrq, .txBitClk, .txSerialOut, .txSerialOe, .txFrameSyncIn,
		.txFrameSyncOut, .txFrameSyncOe, .rxBitClk, .rxSerialIn, .rxFrameSyncIn);
	sfp_codec_model u_sfp_codec_model (.txBitClk, .txFrameSyncIn, .rxBitClk, .rxSerialIn,
		.rxFrameSyncIn, .txSerialOut, .txSerialOe, .txFrameSyncOut, .txFrameSyncOe);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk) begin
		if (txDoneIrq === 1'b1) txIrqs++;
		if (rxDoneIrq === 1'b1) rxIrqs++;
	end

	function automatic logic [15:0] rnd();
		seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
		return seed;
	endfunction : rnd

	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		cmpCount++;
		if (seen !== want) begin
			errors++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, want);
		end
	endtask : check

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmpCount, errors);
		if (errors == 0 && cmpCount > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : summarize

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		memAddr = a;
		memWrData = d;
		memWrEn = 1'b1;
		tick(1);
		memWrEn = 1'b0;
		tick(1);
	endtask : wr

	task automatic rd(input logic [15:0] a, input logic bm, input logic [15:0] want,
		input logic hit);
		memAddr = a;
		blockMove = bm;
		memRdEn = 1'b1;
		tick(1);
		memRdEn = 1'b0;
		blockMove = 1'b0;
		check(memRdData, want);
		check(16'(memRdHit), 16'(hit));
		tick(1);
	endtask : rd

	// k picks the op: load all, word length, set/clear source, set/clear required
	task automatic op(input int k, input logic [2:0] v);
		opStatusValue = v;
		opWordLenValue = v[0];
		{opStatusLoad, opWordLenLoad, opSetSyncSource, opClrSyncSource, opSetSyncReq,
			opClrSyncReq} = 6'h20 >> k;
		tick(1);
		{opStatusLoad, opWordLenLoad, opSetSyncSource, opClrSyncSource, opSetSyncReq,
			opClrSyncReq} = 6'h00;
		tick(1);
		case (k)
			0: mode = v;
			1: mode[0] = v[0];
			2: mode[1] = 1'b1;
			3: mode[1] = 1'b0;
			4: mode[2] = 1'b1;
			default: mode[2] = 1'b0;
		endcase
		check(16'({frameSyncRequired, txSyncSource, wordLengthSelect}), 16'(mode));
	endtask : op

	task automatic tx_word(input logic [15:0] w, input logic pulse, input logic sent);
		int   n, i0, f0;
		logic q[$];
		n = mode[0] ? 8 : 16;
		i0 = txIrqs;
		f0 = u_sfp_codec_model.fsSeen;
		u_sfp_codec_model.txBits.delete();
		wr(16'h0000, w);
		rd(16'h0000, 1'b0, w, 1'b1);
		u_sfp_codec_model.tx_run(n + 9, pulse);
		tick(8);
		q = u_sfp_codec_model.txBits;
		check(16'(q.size()), sent ? 16'(n) : 16'h0000);
		foreach (q[i]) check(16'(q[i]), 16'(w[n-1-i]));
		check(16'(txIrqs - i0), 16'(sent));
		check(16'(u_sfp_codec_model.fsSeen - f0), 16'(sent & mode[1]));
		check(16'({txFrameSyncOe, txSerialOe}), 16'({mode[1], 1'b0}));
	endtask : tx_word

	task automatic rx_word(input logic [15:0] w);
		int n, i0;
		n = mode[0] ? 8 : 16;
		i0 = rxIrqs;
		u_sfp_codec_model.rx_send(w, n, 1'b1);
		tick(8);
		rxHold = mode[0] ? {rxHold[7:0], w[7:0]} : w;
		rd(16'h0001, 1'b0, rxHold, 1'b1);
		check(16'(rxIrqs - i0), 16'h0001);
	endtask : rx_word

	initial begin
		{memWrEn, memRdEn, blockMove, opWordLenLoad, opWordLenValue, opStatusLoad} = 6'h00;
		{opSetSyncSource, opClrSyncSource, opSetSyncReq, opClrSyncReq} = 4'h0;
		{memAddr, memWrData, opStatusValue} = 35'h0;
		holdN = 1'b1;
		sys_rst = 1'b1;
		seed = 16'h0038;
		mode = 3'b100;
		// reset held until both link clocks have ticked too
		fork
			tick(6);
			u_sfp_codec_model.tx_run(4, 1'b0);
			u_sfp_codec_model.rx_send(16'h0000, 0, 1'b0);
		join
		tick(1);
		sys_rst = 1'b0;
		fork
			u_sfp_codec_model.tx_run(4, 1'b0);
			u_sfp_codec_model.rx_send(16'h0000, 0, 1'b0);
		join
		tick(1);
		check(16'({frameSyncRequired, txSyncSource, wordLengthSelect}), 16'(mode));
		check(16'({txSerialOe, txFrameSyncOe}), 16'h0000);
		check(16'(txIrqs + rxIrqs), 16'h0000);
		$display("test reset done");
		rxHold = rnd();
		wr(16'h0001, rxHold);
		rd(16'h0001, 1'b0, rxHold, 1'b1);
		rd(16'h0001, 1'b1, 16'h0000, 1'b0);
		rd(16'h0002, 1'b0, 16'h0000, 1'b0);
		$display("test registers done");
		for (int r = 0; r < 2; r++)
			for (int k = 0; k < 6; k++) op(k, 3'(rnd()));
		$display("test mode ops done");
		op(0, 3'b110);
		tx_word(rnd(), 1'b0, 1'b1);
		op(1, 3'b001);
		tx_word(rnd(), 1'b0, 1'b1);
		$display("test own sync done");
		op(3, 3'b000);
		tx_word(rnd(), 1'b0, 1'b0);
		tx_word(rnd(), 1'b1, 1'b1);
		$display("test external sync done");
		op(1, 3'b000);
		rx_word(rnd());
		op(1, 3'b001);
		rx_word(rnd());
		rx_word(rnd());
		$display("test receive done");
		op(2, 3'b000);
		holdN = 1'b0;
		u_sfp_codec_model.tx_run(4, 1'b0);
		tick(1);
		tx_word(rnd(), 1'b0, 1'b0);
		$display("test hold done");
		holdN = 1.0;
		op(0, 3'b011);
		u_sfp_codec_model.txBits.delete();
		wr(16'h0000, rnd());
		u_sfp_codec_model.tx_run(27, 1'b0);
		check(16'(u_sfp_codec_model.txBits.size()), 16'h0018);
		foreach (u_sfp_codec_model.txBits[i])
			check(16'(u_sfp_codec_model.txBits[i]), 16'(seed[7 - i % 8]));
		$display("test continuous done");
		summarize();
	end

	initial begin
		#900000;
		errors++;
		summarize();
	end
endmodule : framed_serial_port_tb
